// ===== hw/dual_mode_reload_timer_pkg.sv
// Purpose: shared constants for the dual mode reload timer
// Assumes: byte-wide special function register access
// Notes:   offsets are register-space addresses seen on i_sfr_addr
package dual_mode_reload_timer_pkg;

  // register addresses
  localparam logic [7:0] ADDR_CONTROL     = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h95;

  // control field positions
  localparam int BIT_HIGH_OVF   = 7;
  localparam int BIT_LOW_OVF    = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT      = 3;
  localparam int BIT_RUN        = 2;
  localparam int BIT_UNUSED     = 1;
  localparam int BIT_EXT_SEL    = 0;

  // reset values and masks
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'hfd;
  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [7:0] BYTE_MAX      = 8'hff;

  // clock dividers, in system clock cycles and external edges
  localparam int SYSTEM_CLOCK_DIV = 12;
  localparam int EXT_DIV    = 8;

  typedef enum logic [1:0] {
    MODE_WIDE  = 2'b01,
    MODE_SPLIT = 2'b10
  } mode_e;

endpackage : dual_mode_reload_timer_pkg

// ===== hw/count_tick_gen.sv
// Purpose: count-enable pulses for system clock/12 and external clock/8
// Assumes: external oscillator is asynchronous and slower than i_mclk/2
// Notes:   each output is a one-cycle pulse on i_mclk
`timescale 1ns/100ps
`default_nettype none
module count_tick_gen
  import dual_mode_reload_timer_pkg::*;
#(
  parameter int SYS_DIV = SYSTEM_CLOCK_DIV,
  parameter int OSC_DIV = EXT_DIV
) (
  input  wire logic i_mclk,      // system clock
  input  wire logic i_srst,      // synchronous reset, active high
  input  wire logic i_ext_osc,   // raw external oscillator
  output logic      o_sys_tick,  // system clock divided pulse
  output logic      o_ext_tick   // external clock divided pulse
);
  import dual_mode_reload_timer_pkg::*;

  // the divide counters are eight bits wide
  if (SYS_DIV < 2 || SYS_DIV > 256 ||
      OSC_DIV < 2 || OSC_DIV > 256) begin : g_bad_div
    $error("dividers must lie between 2 and 256");
  end

  logic [7:0] sys_cnt_r, sys_cnt_nxt;
  logic [7:0] ext_cnt_r, ext_cnt_nxt;
  logic       meta_r, sync_r, prev_r;
  logic       sys_tick_nxt, ext_tick_nxt;

  always_comb begin
    sys_tick_nxt = 1'b0;
    ext_tick_nxt = 1'b0;
    sys_cnt_nxt  = sys_cnt_r + 8'h01;
    ext_cnt_nxt  = ext_cnt_r;
    if (sys_cnt_r == 8'(SYS_DIV - 1)) begin
      sys_cnt_nxt  = 8'h00;
      sys_tick_nxt = 1'b1;
    end
    // only the second stage and its delayed copy feed the edge detect
    if (sync_r && !prev_r) begin
      ext_cnt_nxt = ext_cnt_r + 8'h01;
      if (ext_cnt_r == 8'(OSC_DIV - 1)) begin
        ext_cnt_nxt  = 8'h00;
        ext_tick_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sys_cnt_r  <= 8'h00;
      ext_cnt_r  <= 8'h00;
      meta_r     <= 1'b0;
      sync_r     <= 1'b0;
      prev_r     <= 1'b0;
      o_sys_tick <= 1'b0;
      o_ext_tick <= 1'b0;
    end else begin
      sys_cnt_r  <= sys_cnt_nxt;
      ext_cnt_r  <= ext_cnt_nxt;
      meta_r     <= i_ext_osc;
      sync_r     <= meta_r;
      prev_r     <= sync_r;
      o_sys_tick <= sys_tick_nxt;
      o_ext_tick <= ext_tick_nxt;
    end
  end

endmodule : count_tick_gen
`default_nettype wire

// ===== hw/lfo_rise_detect.sv
// Purpose: synchronise the low-frequency oscillator and flag rising edges
// Assumes: oscillator is far slower than i_mclk
// Notes:   pulse comes three cycles after the pin rises
`timescale 1ns/100ps
`default_nettype none
module lfo_rise_detect (
  input  wire logic i_mclk,   // system clock
  input  wire logic i_srst,   // synchronous reset, active high
  input  wire logic i_lfo,    // raw low-frequency oscillator
  output logic      o_rise    // one-cycle pulse per rising edge
);

  logic meta_r, sync_r, prev_r, rise_nxt;

  always_comb begin
    rise_nxt = sync_r && !prev_r;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      o_rise <= 1'b0;
    end else begin
      meta_r <= i_lfo;
      sync_r <= meta_r;
      prev_r <= sync_r;
      o_rise <= rise_nxt;
    end
  end

endmodule : lfo_rise_detect
`default_nettype wire

// ===== hw/dual_mode_reload_timer.sv
// Purpose: 16-bit auto-reload timer, splittable into two 8-bit timers
// Assumes: byte register port; clock selects and irq enable come from
//          registers held elsewhere in the system
// Notes:   read data is registered, one cycle after the address
`timescale 1ns/100ps
`default_nettype none
module dual_mode_reload_timer
  import dual_mode_reload_timer_pkg::*;
(
  input  wire logic       i_mclk,            // system clock, 20 MHz
  input  wire logic       i_srst,            // sync reset, active high
  input  wire logic [7:0] i_sfr_addr,        // register address
  input  wire logic [7:0] i_sfr_wdata,       // write data
  input  wire logic       i_sfr_we,          // write strobe, one cycle
  output logic      [7:0] o_sfr_rdata,       // read data, 1 cycle late
  input  wire logic       i_high_byte_clock_select, // high byte system_clock
  input  wire logic       i_low_byte_clock_select,  // low byte system_clock
  input  wire logic       i_timer_irq_enable,       // timer irq enable
  input  wire logic       i_ext_osc,         // external oscillator
  input  wire logic       i_lfo,             // low-frequency oscillator
  output logic            o_irq              // interrupt request level
);
  import dual_mode_reload_timer_pkg::*;

  function automatic logic is_max(input logic [7:0] b);
    return b == BYTE_MAX;
  endfunction : is_max

  function automatic logic wr_hit(input logic       we,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    return we && (addr == target);
  endfunction : wr_hit

  logic sys_tick, ext_tick, lfo_rise;

  count_tick_gen u_ticks (
    .i_mclk     (i_mclk),
    .i_srst     (i_srst),
    .i_ext_osc  (i_ext_osc),
    .o_sys_tick (sys_tick),
    .o_ext_tick (ext_tick)
  );

  lfo_rise_detect u_lfo (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .i_lfo  (i_lfo),
    .o_rise (lfo_rise)
  );

  // ---------------- register state
  logic [7:0] control_r, control_nxt;
  logic [7:0] reload_low_r, reload_low_nxt;
  logic [7:0] reload_high_r, reload_high_nxt;
  logic [7:0] count_low_r, count_low_nxt;
  logic [7:0] count_high_r, count_high_nxt;
  logic       capture_irq_r, capture_irq_nxt;
  logic [7:0] rdata_nxt;

  logic  wr_ctl, wr_rll, wr_rlh, wr_cl, wr_ch;
  logic  run, split, ext_sel, low_irq_en, capture_en;
  logic  low_tick, high_tick, low_wrap, high_wrap, capture;
  mode_e mode;

  assign wr_ctl = wr_hit(i_sfr_we, i_sfr_addr, ADDR_CONTROL);
  assign wr_rll = wr_hit(i_sfr_we, i_sfr_addr, ADDR_RELOAD_LOW);
  assign wr_rlh = wr_hit(i_sfr_we, i_sfr_addr, ADDR_RELOAD_HIGH);
  assign wr_cl  = wr_hit(i_sfr_we, i_sfr_addr, ADDR_COUNT_LOW);
  assign wr_ch  = wr_hit(i_sfr_we, i_sfr_addr, ADDR_COUNT_HIGH);

  assign run        = control_r[BIT_RUN];
  assign split      = control_r[BIT_SPLIT];
  assign ext_sel    = control_r[BIT_EXT_SEL];
  assign low_irq_en = control_r[BIT_LOW_IRQ_EN];
  assign capture_en = control_r[BIT_CAPTURE_EN];
  assign mode       = split ? MODE_SPLIT : MODE_WIDE;

  // each byte picks its own source; 16-bit mode uses the low select
  assign low_tick  = i_low_byte_clock_select ? 1'b1 :
                     (ext_sel ? ext_tick : sys_tick);
  assign high_tick = i_high_byte_clock_select ? 1'b1 :
                     (ext_sel ? ext_tick : sys_tick);

  // capture needs the timer irq enable as well as its own bit
  assign capture = capture_en && i_timer_irq_enable && lfo_rise;

  // ---------------- counting and flags
  always_comb begin
    count_low_nxt  = count_low_r;
    count_high_nxt = count_high_r;
    low_wrap       = 1'b0;
    high_wrap      = 1'b0;
    unique case (mode)
      MODE_WIDE: begin
        if (run && low_tick) begin
          low_wrap      = is_max(count_low_r);
          count_low_nxt = count_low_r + 8'h01;
          if (low_wrap) begin
            count_high_nxt = count_high_r + 8'h01;
            high_wrap      = is_max(count_high_r);
          end
          if (high_wrap) begin
            count_low_nxt  = reload_low_r;
            count_high_nxt = reload_high_r;
          end
        end
      end
      MODE_SPLIT: begin
        if (low_tick) begin
          low_wrap      = is_max(count_low_r);
          count_low_nxt = low_wrap ? reload_low_r
                                   : count_low_r + 8'h01;
        end
        if (run && high_tick) begin
          high_wrap      = is_max(count_high_r);
          count_high_nxt = high_wrap ? reload_high_r
                                     : count_high_r + 8'h01;
        end
      end
    endcase
    // software writes override the count for that cycle
    if (wr_cl) count_low_nxt = i_sfr_wdata;
    if (wr_ch) count_high_nxt = i_sfr_wdata;
  end

  always_comb begin
    control_nxt = control_r;
    if (wr_ctl) begin
      control_nxt = (i_sfr_wdata & CONTROL_WMASK);
    end
    // a wrap in the same cycle as a clearing write keeps its flag set
    if (high_wrap) control_nxt[BIT_HIGH_OVF] = 1'b1;
    if (low_wrap) control_nxt[BIT_LOW_OVF] = 1'b1;
    control_nxt[BIT_UNUSED] = 1'b0;
  end

  always_comb begin
    reload_low_nxt  = wr_rll ? i_sfr_wdata : reload_low_r;
    reload_high_nxt = wr_rlh ? i_sfr_wdata : reload_high_r;
    // the captured value beats a same-cycle reload write
    if (capture) begin
      reload_low_nxt  = count_low_r;
      reload_high_nxt = count_high_r;
    end
    capture_irq_nxt = capture;
  end

  always_comb begin
    unique case (i_sfr_addr)
      ADDR_CONTROL:     rdata_nxt = control_r;
      ADDR_RELOAD_LOW:  rdata_nxt = reload_low_r;
      ADDR_RELOAD_HIGH: rdata_nxt = reload_high_r;
      ADDR_COUNT_LOW:   rdata_nxt = count_low_r;
      ADDR_COUNT_HIGH:  rdata_nxt = count_high_r;
      default:          rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      control_r     <= CONTROL_RESET;
      reload_low_r  <= BYTE_RESET;
      reload_high_r <= BYTE_RESET;
      count_low_r   <= BYTE_RESET;
      count_high_r  <= BYTE_RESET;
      capture_irq_r <= 1'b0;
      o_sfr_rdata   <= 8'h00;
    end else begin
      control_r     <= control_nxt;
      reload_low_r  <= reload_low_nxt;
      reload_high_r <= reload_high_nxt;
      count_low_r   <= count_low_nxt;
      count_high_r  <= count_high_nxt;
      capture_irq_r <= capture_irq_nxt;
      o_sfr_rdata   <= rdata_nxt;
    end
  end

  // level request from the sticky flags; software must read both flags
  // to learn the source, and the capture request lasts one cycle
  always_comb begin
    o_irq = i_timer_irq_enable &&
            (control_r[BIT_HIGH_OVF] ||
             (low_irq_en && control_r[BIT_LOW_OVF]) ||
             capture_irq_r);
  end

  // ---------------- assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence s_wide_wrap;
    !split && run && low_tick && is_max(count_low_r) &&
    is_max(count_high_r) && !wr_cl && !wr_ch;
  endsequence

  sequence s_reloaded;
    count_low_r == $past(reload_low_r) &&
    count_high_r == $past(reload_high_r) && control_r[BIT_HIGH_OVF];
  endsequence

  sequence s_capture_seen;
    reload_low_r == $past(count_low_r) &&
    reload_high_r == $past(count_high_r) && capture_irq_r && o_irq;
  endsequence

  AST_WIDE_WRAP: assert property (s_wide_wrap |=> s_reloaded)
    else $error("16-bit wrap did not reload or set high flag");

  AST_IRQ_HIGH: assert property (
    i_timer_irq_enable && control_r[BIT_HIGH_OVF] |-> o_irq)
    else $error("high flag with irq enabled did not request irq");

  AST_IRQ_LOW: assert property (
    !i_timer_irq_enable || !(low_irq_en && control_r[BIT_LOW_OVF]) ||
    o_irq)
    else $error("enabled low flag did not request irq");

  AST_SPLIT_LOW: assert property (
    split && !run && low_tick && !is_max(count_low_r) && !wr_cl
    |=> count_low_r == $past(count_low_r) + 8'h01)
    else $error("split low byte stopped without run bit");

  AST_SPLIT_LOW_RELOAD: assert property (
    split && low_tick && is_max(count_low_r) && !wr_cl
    |=> count_low_r == $past(reload_low_r) &&
        control_r[BIT_LOW_OVF])
    else $error("split low byte did not reload or flag");

  AST_STOPPED: assert property (
    !run && !split && !wr_cl && !wr_ch
    |=> $stable(count_low_r) && $stable(count_high_r))
    else $error("stopped 16-bit timer changed count");

  AST_SPLIT_HIGH_HOLD: assert property (
    split && !run && !wr_ch |=> $stable(count_high_r))
    else $error("split high byte moved while not running");

  AST_STICKY: assert property (
    control_r[BIT_HIGH_OVF] && !wr_ctl
    |=> control_r[BIT_HIGH_OVF])
    else $error("high overflow flag cleared without a write");

  AST_STICKY_LOW: assert property (
    control_r[BIT_LOW_OVF] && !wr_ctl
    |=> control_r[BIT_LOW_OVF])
    else $error("low overflow flag cleared without a write");

  AST_UNUSED_ZERO: assert property (
    wr_ctl ##1 1'b1 |-> !control_r[BIT_UNUSED])
    else $error("unused control bit became set");

  AST_CAPTURE: assert property (capture |=> s_capture_seen)
    else $error("capture did not copy count or request irq");

  AST_SYS_DIV: assert property (
    sys_tick |=> !sys_tick [*8] ##1 !sys_tick [*3] ##1 sys_tick)
    else $error("divide by twelve pulse spacing wrong");

  AST_WRITE_LANDS: assert property (
    wr_ch |=> count_high_r == $past(i_sfr_wdata))
    else $error("count high write did not land next cycle");

endmodule : dual_mode_reload_timer
`default_nettype wire

// ===== verification/dual_mode_reload_timer_tb.sv
// Purpose: self-checking bench for the dual mode reload timer
// Assumes: register port timing as handed over; irq enable is a plain input
// Notes:   counts are checked with the timer stopped, so reads never race
`timescale 1ns/100ps
`default_nettype none
module dual_mode_reload_timer_tb;
  import dual_mode_reload_timer_pkg::*;

  logic       i_mclk;
  logic       i_srst;
  logic [7:0] i_sfr_addr;
  logic [7:0] i_sfr_wdata;
  logic       i_sfr_we;
  logic [7:0] o_sfr_rdata;
  logic       i_high_byte_clock_select;
  logic       i_low_byte_clock_select;
  logic       i_timer_irq_enable;
  logic       i_ext_osc;
  logic       i_lfo;
  logic       o_irq;
  logic [1:0] osc_div;
  int         fails;
  int         check_count;
  int         cyc;
  int         pulses;
  logic [7:0] irq_ctl [8];
  logic       irq_exp [8];

  dual_mode_reload_timer dut_u (
    .i_mclk                   (i_mclk),
    .i_srst                   (i_srst),
    .i_sfr_addr               (i_sfr_addr),
    .i_sfr_wdata              (i_sfr_wdata),
    .i_sfr_we                 (i_sfr_we),
    .o_sfr_rdata              (o_sfr_rdata),
    .i_high_byte_clock_select (i_high_byte_clock_select),
    .i_low_byte_clock_select  (i_low_byte_clock_select),
    .i_timer_irq_enable       (i_timer_irq_enable),
    .i_ext_osc                (i_ext_osc),
    .i_lfo                    (i_lfo),
    .o_irq                    (o_irq)
  );

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // external oscillator at a quarter of the system clock, 2 cycles per level
  always @(posedge i_mclk) begin
    if (i_srst) begin
      osc_div <= 2'd0;
      i_ext_osc <= 1'b0;
    end else begin
      osc_div <= osc_div + 2'd1;
      i_ext_osc <= osc_div[1];
    end
  end

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_we <= 1'b1;
    @(posedge i_mclk);
    i_sfr_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_sfr_addr <= a;
    @(posedge i_mclk);
    #1;
    chk(o_sfr_rdata, exp);
  endtask : rd

  task automatic set_count(input logic [7:0] lo, input logic [7:0] hi);
    wr(ADDR_COUNT_LOW, lo);
    wr(ADDR_COUNT_HIGH, hi);
  endtask : set_count

  // the timer sees n+2 counting edges: the stop write lands on the last one
  task automatic run_for(input logic [7:0] ctl, input int n);
    wr(ADDR_CONTROL, ctl);
    repeat (n) @(posedge i_mclk);
    wr(ADDR_CONTROL, 8'h00);
  endtask : run_for

  task automatic timed(input logic sel, input logic [7:0] ctl,
                       input int n, input logic [7:0] exp);
    i_low_byte_clock_select <= sel;
    set_count(8'h00, 8'h00);
    run_for(ctl, n);
    rd(ADDR_COUNT_LOW, exp);
  endtask : timed

  initial begin
    i_srst = 1'b1;
    i_sfr_addr = 8'h00;
    i_sfr_wdata = 8'h00;
    i_sfr_we = 1'b0;
    i_high_byte_clock_select = 1'b0;
    i_low_byte_clock_select = 1'b0;
    i_timer_irq_enable = 1'b0;
    i_lfo = 1'b0;
    fails = 0;
    check_count = 0;
    irq_ctl = '{8'h80, 8'h40, 8'h60, 8'h20, 8'h88, 8'h48, 8'h68, 8'h28};
    irq_exp = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    repeat (4) @(posedge i_mclk);
    i_srst <= 1'b0;
    // reset values, unmapped neighbours read zero
    for (int a = 8'h90; a <= 8'h96; a++) begin
      rd(8'(a), 8'h00);
    end
    wr(ADDR_CONTROL, 8'hff);
    rd(ADDR_CONTROL, 8'hfd);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    for (int a = 8'h92; a <= 8'h95; a++) begin
      wr(8'(a), 8'(a) ^ 8'h5a);
      rd(8'(a), 8'(a) ^ 8'h5a);
    end
    // 16-bit wrap; the wrap meets the stopping write, the flags must win
    i_low_byte_clock_select <= 1'b1;
    wr(ADDR_RELOAD_LOW, 8'h34);
    wr(ADDR_RELOAD_HIGH, 8'h12);
    set_count(8'hfe, 8'hff);
    run_for(8'h04, 0);
    rd(ADDR_CONTROL, 8'hc0);
    rd(ADDR_COUNT_HIGH, 8'h12);
    repeat (5) @(posedge i_mclk);
    rd(ADDR_COUNT_LOW, 8'h34);
    // interrupt request from flags in both modes
    i_low_byte_clock_select <= 1'b0;
    i_timer_irq_enable <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CONTROL, irq_ctl[k]);
      #1;
      chk({7'h00, o_irq}, {7'h00, irq_exp[k]});
    end
    i_timer_irq_enable <= 1'b0;
    wr(ADDR_CONTROL, 8'h80);
    #1;
    chk({7'h00, o_irq}, 8'h00);
    // split: low byte runs with run clear, high byte held until run is set
    i_low_byte_clock_select <= 1'b1;
    i_high_byte_clock_select <= 1'b1;
    wr(ADDR_RELOAD_LOW, 8'h10);
    wr(ADDR_RELOAD_HIGH, 8'h20);
    set_count(8'hfe, 8'hfe);
    run_for(8'h08, 0);
    rd(ADDR_CONTROL, 8'h40);
    rd(ADDR_COUNT_LOW, 8'h10);
    rd(ADDR_COUNT_HIGH, 8'hfe);
    set_count(8'h00, 8'hfe);
    run_for(8'h0c, 0);
    rd(ADDR_CONTROL, 8'h80);
    rd(ADDR_COUNT_HIGH, 8'h20);
    rd(ADDR_COUNT_LOW, 8'h02);
    // clock sources over fixed windows of counting edges
    i_high_byte_clock_select <= 1'b0;
    timed(1'b0, 8'h04, 22, 8'h02);
    timed(1'b0, 8'h05, 94, 8'h03);
    timed(1'b1, 8'h05, 22, 8'h18);
    // capture from the low-frequency oscillator
    set_count(8'hcd, 8'hab);
    wr(ADDR_RELOAD_LOW, 8'h11);
    wr(ADDR_RELOAD_HIGH, 8'h22);
    i_timer_irq_enable <= 1'b1;
    @(posedge i_mclk);
    i_lfo <= 1'b1;
    repeat (8) @(posedge i_mclk);
    i_lfo <= 1'b0;
    rd(ADDR_RELOAD_LOW, 8'h11);
    wr(ADDR_CONTROL, 8'h10);
    repeat (6) @(posedge i_mclk);
    i_lfo <= 1'b1;
    pulses = 0;
    repeat (10) begin
      @(posedge i_mclk);
      #1;
      if (o_irq === 1'b1)
        pulses++;
    end
    chk(8'(pulses), 8'h01);
    rd(ADDR_RELOAD_LOW, 8'hcd);
    rd(ADDR_RELOAD_HIGH, 8'hab);
    // reset with capture enabled and run clear clears the captured reload and the control bits
    i_srst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd(ADDR_RELOAD_LOW, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_HIGH, 8'h00);
    test_done();
  end

endmodule : dual_mode_reload_timer_tb
`default_nettype wire
